// file: port78_gpio.sv
// Purpose: port 7 and port 8 general I/O with timer V / timer W sharing
// Assumes: timer settings arrive on hclk; pins are asynchronous
// Notes:   zero-wait-state AHB-Lite slave, every answer OKAY
`timescale 1ns/1ps

// How it works
// - port 7 direction bit: 1 output, 0 input
// - timer V select beats direction on pin 6
// - select 0000 gives port pin, else timer
// - pins 5 and 4 always feed timer V
// - port 7 latch drives its output pins
// - port 7 read: latch if output, else pin
// - port 7 bits 7 and 3..0 read one
// - port 8 direction bit: 1 output, 0 input
// - timer W settings beat port on pins 4..1
// - pin 0 always feeds timer W clock
// - port 8 latch drives its output pins
// - port 8 read: latch if output, else pin
// - codes 001, 01x make timer W output
module port78_gpio
(
	// bus clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output logic             hreadyout,
	output logic             hresp,
	output logic      [31:0] hrdata,
	// timer V side
	input  wire logic [3:0]  timer_v_output_select,
	input  wire logic        timer_v_output,
	output logic             timer_v_clock_input,
	output logic             timer_v_reset_input,
	// timer W side, channels a..d on bits 0..3
	input  wire logic [11:0] timer_w_io_control,
	input  wire logic [3:0]  timer_w_channel_out,
	output logic      [3:0]  timer_w_channel_in,
	output logic             timer_w_clock_input,
	// port 7 pins 6..4
	input  wire logic [6:4]  p7_pin_in,
	output logic      [6:4]  p7_pin_out,
	output logic      [6:4]  p7_pin_oe_n,
	// port 8 pins 7..0
	input  wire logic [7:0]  p8_pin_in,
	output logic      [7:0]  p8_pin_out,
	output logic      [7:0]  p8_pin_oe_n
);

	logic [6:4]                p7_dir_q;
	logic [6:4]                p7_dir_d;
	logic [6:4]                p7_lat_q;
	logic [6:4]                p7_lat_d;
	logic [7:0]                p8_dir_q;
	logic [7:0]                p8_dir_d;
	logic [7:0]                p8_lat_q;
	logic [7:0]                p8_lat_d;
	logic [6:4]                p7_meta_q;
	logic [6:4]                p7_sync_q;
	logic [7:0]                p8_meta_q;
	logic [7:0]                p8_sync_q;
	logic                      addr_phase;
	logic                      wr_pend_q;
	port78_pkg::reg_sel_t      wr_sel_q;
	port78_pkg::reg_sel_t      rd_sel;
	logic                      hreadyout_q;
	logic                      hresp_q;
	logic [31:0]               hrdata_q;
	logic [6:4]                p7_out_d;
	logic [6:4]                p7_oe_n_d;
	logic [6:4]                p7_out_q;
	logic [6:4]                p7_oe_n_q;
	logic [7:0]                p8_out_d;
	logic [7:0]                p8_oe_n_d;
	logic [7:0]                p8_out_q;
	logic [7:0]                p8_oe_n_q;

	function automatic port78_pkg::reg_sel_t decode(input logic [7:0] a);
		port78_pkg::reg_sel_t s;
		s = port78_pkg::SEL_NONE;
		case (a)
			port78_pkg::OFF_P7_DIR: s = port78_pkg::SEL_P7_DIR;
			port78_pkg::OFF_P7_LAT: s = port78_pkg::SEL_P7_LAT;
			port78_pkg::OFF_P8_DIR: s = port78_pkg::SEL_P8_DIR;
			port78_pkg::OFF_P8_LAT: s = port78_pkg::SEL_P8_LAT;
			default:                s = port78_pkg::SEL_NONE;
		endcase
		return s;
	endfunction

	function automatic logic tw_is_timer(input logic [2:0] code);
		return (code == port78_pkg::TW_CODE_OUT)
			|| (code[2:1] == port78_pkg::TW_CODE_OUT_HI);
	endfunction

	// pins are asynchronous: two flops before any use
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			p7_meta_q <= '0;
			p7_sync_q <= '0;
			p8_meta_q <= '0;
			p8_sync_q <= '0;
		end
		else
		begin
			p7_meta_q <= p7_pin_in;
			p7_sync_q <= p7_meta_q;
			p8_meta_q <= p8_pin_in;
			p8_sync_q <= p8_meta_q;
		end
	end

	assign timer_v_clock_input = p7_sync_q[port78_pkg::P7_TCLK_BIT];
	assign timer_v_reset_input = p7_sync_q[port78_pkg::P7_TRST_BIT];
	assign timer_w_clock_input = p8_sync_q[port78_pkg::P8_TCLK_BIT];
	assign timer_w_channel_in =
		p8_sync_q[port78_pkg::P8_TW_HI:port78_pkg::P8_TW_LO];

	// bus address phase; only word writes land in a register
	assign addr_phase = hsel && hready
		&& (htrans == port78_pkg::HTRANS_NONSEQ
		|| htrans == port78_pkg::HTRANS_SEQ);
	assign rd_sel = decode(haddr[7:0]);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_q <= 1'b0;
			wr_sel_q  <= port78_pkg::SEL_NONE;
		end
		else if (hready)
		begin
			wr_pend_q <= addr_phase && hwrite
				&& (hsize == port78_pkg::HSIZE_WORD);
			wr_sel_q  <= rd_sel;
		end
	end

	// write data arrives in the data phase
	always_comb
	begin
		p7_dir_d = p7_dir_q;
		p7_lat_d = p7_lat_q;
		p8_dir_d = p8_dir_q;
		p8_lat_d = p8_lat_q;
		if (wr_pend_q)
		begin
			case (wr_sel_q)
				port78_pkg::SEL_P7_DIR: p7_dir_d = hwdata[6:4];
				port78_pkg::SEL_P7_LAT: p7_lat_d = hwdata[6:4];
				port78_pkg::SEL_P8_DIR: p8_dir_d = hwdata[7:0];
				port78_pkg::SEL_P8_LAT: p8_lat_d = hwdata[7:0];
				default: p7_dir_d = p7_dir_q;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			p7_dir_q <= port78_pkg::DIR_RESET[6:4];
			p7_lat_q <= port78_pkg::LAT_RESET[6:4];
			p8_dir_q <= port78_pkg::DIR_RESET;
			p8_lat_q <= port78_pkg::LAT_RESET;
		end
		else
		begin
			p7_dir_q <= p7_dir_d;
			p7_lat_q <= p7_lat_d;
			p8_dir_q <= p8_dir_d;
			p8_lat_q <= p8_lat_d;
		end
	end

	// read data built from the _d values, so a read right after a
	// write to the same register sees the new value
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata_q <= '0;
		else if (addr_phase && !hwrite)
		begin
			case (rd_sel)
				port78_pkg::SEL_P7_LAT: hrdata_q <= {port78_pkg::WORD_PAD,
					port78_pkg::P7_ONES | {1'b0,
					(p7_dir_d & p7_lat_d) | (~p7_dir_d & p7_sync_q), 4'h0}};
				port78_pkg::SEL_P8_LAT: hrdata_q <= {port78_pkg::WORD_PAD,
					(p8_dir_d & p8_lat_d) | (~p8_dir_d & p8_sync_q)};
				// direction registers are write-only
				default: hrdata_q <= {port78_pkg::WORD_PAD,
					port78_pkg::WO_READ};
			endcase
		end
	end

	// never stalls and never errors
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hreadyout_q <= 1'b1;
			hresp_q     <= port78_pkg::HRESP_OKAY;
		end
		else
		begin
			hreadyout_q <= 1'b1;
			hresp_q     <= port78_pkg::HRESP_OKAY;
		end
	end

	assign hreadyout = hreadyout_q;
	assign hresp     = hresp_q;
	assign hrdata    = hrdata_q;

	// port 7 pin drive
	always_comb
	begin
		p7_out_d  = p7_lat_q;
		p7_oe_n_d = ~p7_dir_q;
		if (timer_v_output_select != port78_pkg::TV_OS_PORT)
		begin
			p7_out_d[port78_pkg::P7_TMO_BIT]  = timer_v_output;
			p7_oe_n_d[port78_pkg::P7_TMO_BIT] = 1'b0;
		end
	end

	// port 8 pin drive
	genvar i;
	generate
		for (i = 0; i < 8; i++)
		begin : g_p8
			if (i >= port78_pkg::P8_TW_LO && i <= port78_pkg::P8_TW_HI)
			begin : g_tw
				logic tw_out;
				assign tw_out = tw_is_timer(timer_w_io_control[
					port78_pkg::TW_CODE_W * (i - port78_pkg::P8_TW_LO)
					+: port78_pkg::TW_CODE_W]);
				assign p8_out_d[i]  = tw_out
					? timer_w_channel_out[i - port78_pkg::P8_TW_LO]
					: p8_lat_q[i];
				assign p8_oe_n_d[i] = tw_out ? 1'b0 : ~p8_dir_q[i];
			end
			else
			begin : g_plain
				assign p8_out_d[i]  = p8_lat_q[i];
				assign p8_oe_n_d[i] = ~p8_dir_q[i];
			end
		end
	endgenerate

	// registered pins cost one cycle but keep outputs glitch-free
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			p7_out_q  <= port78_pkg::LAT_RESET[6:4];
			p7_oe_n_q <= port78_pkg::OE_N_RESET[6:4];
			p8_out_q  <= port78_pkg::LAT_RESET;
			p8_oe_n_q <= port78_pkg::OE_N_RESET;
		end
		else
		begin
			p7_out_q  <= p7_out_d;
			p7_oe_n_q <= p7_oe_n_d;
			p8_out_q  <= p8_out_d;
			p8_oe_n_q <= p8_oe_n_d;
		end
	end

	assign p7_pin_out  = p7_out_q;
	assign p7_pin_oe_n = p7_oe_n_q;
	assign p8_pin_out  = p8_out_q;
	assign p8_pin_oe_n = p8_oe_n_q;

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	property p_p7_dir;
		$past(timer_v_output_select) == port78_pkg::TV_OS_PORT
		|-> p7_oe_n_q == ~$past(p7_dir_q);
	endproperty
	a_p7_dir: assert property (p_p7_dir)
		else $error("port 7 enable does not follow direction");

	property p_tv_pri;
		$past(timer_v_output_select) != port78_pkg::TV_OS_PORT
		|-> !p7_oe_n_q[6] && p7_out_q[6] == $past(timer_v_output);
	endproperty
	a_tv_pri: assert property (p_tv_pri)
		else $error("timer V output not on pin 6");

	property p_tv_in;
		hresetn |-> ##2 timer_v_clock_input == $past(p7_pin_in[5], 2)
		&& timer_v_reset_input == $past(p7_pin_in[4], 2);
	endproperty
	a_tv_in: assert property (p_tv_in)
		else $error("timer V inputs not fed from pins");

	property p_p8_wr;
		wr_pend_q && wr_sel_q == port78_pkg::SEL_P8_LAT
		|=> p8_lat_q == $past(hwdata[7:0]) ##1 p8_out_q[7] == p8_lat_q[7];
	endproperty
	a_p8_wr: assert property (p_p8_wr)
		else $error("port 8 latch write lost");

	property p_p7_rd;
		addr_phase && !hwrite && rd_sel == port78_pkg::SEL_P7_LAT
		|=> hrdata_q[7] && hrdata_q[3:0] == 4'hF
		&& hrdata_q[6:4] == (($past(p7_dir_d) & $past(p7_lat_d))
		| (~$past(p7_dir_d) & $past(p7_sync_q)));
	endproperty
	a_p7_rd: assert property (p_p7_rd)
		else $error("port 7 read value wrong");

	property p_p8_rd;
		addr_phase && !hwrite && rd_sel == port78_pkg::SEL_P8_LAT
		|=> hrdata_q[7:0] == (($past(p8_dir_d) & $past(p8_lat_d))
		| (~$past(p8_dir_d) & $past(p8_sync_q)));
	endproperty
	a_p8_rd: assert property (p_p8_rd)
		else $error("port 8 read value wrong");

	property p_tw_out;
		tw_is_timer(timer_w_io_control[2:0])
		|=> !p8_oe_n_q[1] && p8_out_q[1] == $past(timer_w_channel_out[0]);
	endproperty
	a_tw_out: assert property (p_tw_out)
		else $error("timer W channel a not driving pin 1");

	property p_tw_clk;
		hresetn |-> ##2 timer_w_clock_input == $past(p8_pin_in[0], 2);
	endproperty
	a_tw_clk: assert property (p_tw_clk)
		else $error("timer W clock not fed from pin 0");

	property p_p8_dir;
		!tw_is_timer(timer_w_io_control[11:9])
		|=> p8_oe_n_q[4] == !$past(p8_dir_q[4]);
	endproperty
	a_p8_dir: assert property (p_p8_dir)
		else $error("port 8 pin 4 enable does not follow direction");

endmodule

// file: port78_pkg.sv
// Purpose: shared constants and types for the port 7 / port 8 pin logic
// Assumes: 32-bit AHB-Lite register bus, one word per register
// Notes:   register offsets are byte addresses within the slave window
package port78_pkg;

	// register byte offsets, decoded on the low address byte
	localparam logic [7:0] OFF_P7_DIR = 8'h00;
	localparam logic [7:0] OFF_P7_LAT = 8'h04;
	localparam logic [7:0] OFF_P8_DIR = 8'h08;
	localparam logic [7:0] OFF_P8_LAT = 8'h0C;

	// reset values
	localparam logic [7:0] DIR_RESET  = 8'h00;
	localparam logic [7:0] LAT_RESET  = 8'h00;
	localparam logic [7:0] OE_N_RESET = 8'hFF;

	// port 7 read-back: unimplemented bits 7 and 3..0 read as one
	localparam logic [7:0] P7_ONES    = 8'h8F;
	localparam logic [7:0] WO_READ    = 8'h00;
	localparam logic [23:0] WORD_PAD  = 24'h000000;

	// timer V output-select value that leaves the pin to the port
	localparam logic [3:0] TV_OS_PORT = 4'h0;

	// timer W I/O control codes that make a pin a timer output
	localparam logic [2:0] TW_CODE_OUT    = 3'h1;
	localparam logic [1:0] TW_CODE_OUT_HI = 2'h1;
	localparam int         TW_CODE_W      = 3;

	// pin positions
	localparam int P7_TMO_BIT  = 6;
	localparam int P7_TCLK_BIT = 5;
	localparam int P7_TRST_BIT = 4;
	localparam int P8_TCLK_BIT = 0;
	localparam int P8_TW_LO    = 1;
	localparam int P8_TW_HI    = 4;

	// AHB-Lite encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HTRANS_SEQ    = 2'h3;
	localparam logic [2:0] HSIZE_WORD    = 3'h2;
	localparam logic       HRESP_OKAY    = 1'b0;

	typedef enum logic [3:0]
	{
		SEL_NONE   = 4'b0000,
		SEL_P7_DIR = 4'b0001,
		SEL_P7_LAT = 4'b0010,
		SEL_P8_DIR = 4'b0100,
		SEL_P8_LAT = 4'b1000
	} reg_sel_t;

endpackage

// file: pin_world.sv
// Purpose: board side of the port 7 / port 8 pins
// Assumes: every pin also has a weak board driver set by the bench
// Notes:   a pin driven by the port shows the port level, else the board
`timescale 1ns/1ps
module pin_world
(
	// port drivers
	input  wire logic [6:4] p7_out,
	input  wire logic [6:4] p7_oe_n,
	input  wire logic [7:0] p8_out,
	input  wire logic [7:0] p8_oe_n,
	// board levels
	input  wire logic [6:4] ext7,
	input  wire logic [7:0] ext8,
	// resolved pin levels
	output logic      [6:4] p7_level,
	output logic      [7:0] p8_level
);
	// board driver is weak, so an enabled port driver always wins
	assign p7_level = (p7_oe_n & ext7) | (~p7_oe_n & p7_out);
	assign p8_level = (p8_oe_n & ext8) | (~p8_oe_n & p8_out);
endmodule

// file: port78_gpio_tb_top.sv
// Purpose: self-checking bench for the port 7 / port 8 pin logic
// Assumes: zero-wait-state slave, pins settle within four cycles
// Notes:   board levels differ from the latches so read-back shows source
`timescale 1ns/1ps
`define CHK(got, exp) \
	begin \
		n_tests++; \
		if ((got) !== (exp)) \
		begin \
			n_errors++; \
			$display("wrong value at %0t: got %h want %h", $time, got, exp); \
		end \
	end
module port78_gpio_tb_top;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h00000000;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] hwdata = 32'h00000000;
	logic        hreadyout;
	logic        hresp;
	logic [31:0] hrdata;
	logic [3:0]  tv_sel = 4'h0;
	logic        tv_out = 1'b0;
	logic        tv_clk;
	logic        tv_rst;
	logic        tw_clk;
	logic [11:0] tw_ctl = 12'h000;
	logic [3:0]  tw_out = 4'h0;
	logic [3:0]  tw_in;
	logic [6:4]  ext7 = 3'h0;
	logic [6:4]  p7_lvl;
	logic [6:4]  p7_out;
	logic [6:4]  p7_oe_n;
	logic [7:0]  ext8 = 8'h00;
	logic [7:0]  p8_lvl;
	logic [7:0]  p8_out;
	logic [7:0]  p8_oe_n;
	int          n_errors = 0;
	int          n_tests = 0;
	int          cycles = 0;
	logic [31:0] rd;

	always #10 hclk = ~hclk;

	port78_gpio dut
	(
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
		.hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .timer_v_output_select(tv_sel),
		.timer_v_output(tv_out), .timer_v_clock_input(tv_clk),
		.timer_v_reset_input(tv_rst), .timer_w_io_control(tw_ctl),
		.timer_w_channel_out(tw_out), .timer_w_channel_in(tw_in),
		.timer_w_clock_input(tw_clk), .p7_pin_in(p7_lvl),
		.p7_pin_out(p7_out), .p7_pin_oe_n(p7_oe_n), .p8_pin_in(p8_lvl),
		.p8_pin_out(p8_out), .p8_pin_oe_n(p8_oe_n)
	);

	pin_world board
	(
		.p7_out(p7_out), .p7_oe_n(p7_oe_n), .p8_out(p8_out),
		.p8_oe_n(p8_oe_n), .ext7(ext7), .ext8(ext8),
		.p7_level(p7_lvl), .p8_level(p8_lvl)
	);

	task automatic test_done();
		$display("tests %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// whole run needs well under a thousand cycles
	always @(posedge hclk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			n_errors++;
			test_done();
		end
	end

	// one single word transfer; read data is taken at the data phase edge
	task automatic xfer(input logic [7:0] a, input logic w,
		input logic [31:0] wd);
		hsel   <= 1'b1;
		htrans <= port78_pkg::HTRANS_NONSEQ;
		haddr  <= {24'h000000, a};
		hwrite <= w;
		hsize  <= port78_pkg::HSIZE_WORD;
		@(posedge hclk);
		while (hreadyout !== 1'b1)
			@(posedge hclk);
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge hclk);
		while (hreadyout !== 1'b1)
			@(posedge hclk);
		rd = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		xfer(a, 1'b1, {24'h000000, d});
	endtask

	// two sync flops plus one output flop, with margin
	task automatic settle();
		repeat (4) @(posedge hclk);
	endtask

	task automatic t_reset();
		ext7 <= 3'h5;
		settle();
		`CHK(p7_oe_n, 3'h7)
		`CHK(p8_oe_n, 8'hFF)
		`CHK(p8_out, 8'h00)
		xfer(port78_pkg::OFF_P7_LAT, 1'b0, 32'h0);
		`CHK(rd, 32'h000000DF)
		// unmapped place: write lost, read zero
		wr(8'h10, 8'hFF);
		xfer(8'h10, 1'b0, 32'h0);
		`CHK(rd, 32'h00000000)
		`CHK(hresp, port78_pkg::HRESP_OKAY)
		$display("reset test done");
	endtask

	task automatic t_port7();
		wr(port78_pkg::OFF_P7_DIR, 8'h70);
		wr(port78_pkg::OFF_P7_LAT, 8'h50);
		ext7 <= 3'h2;
		settle();
		`CHK(p7_oe_n, 3'h0)
		`CHK(p7_out, 3'h5)
		// timer V pulls pin 6 low, so only the latch can read back one
		tv_sel <= 4'h1;
		tv_out <= 1'b0;
		settle();
		xfer(port78_pkg::OFF_P7_LAT, 1'b0, 32'h0);
		`CHK(rd, 32'h000000DF)
		tv_sel <= 4'h0;
		// latch differs from the board on input pin 6
		wr(port78_pkg::OFF_P7_DIR, 8'h20);
		wr(port78_pkg::OFF_P7_LAT, 8'h20);
		ext7 <= 3'h4;
		settle();
		`CHK(p7_oe_n, 3'h5)
		xfer(port78_pkg::OFF_P7_LAT, 1'b0, 32'h0);
		`CHK(rd, 32'h000000EF)
		`CHK(tv_clk, 1'b1)
		`CHK(tv_rst, 1'b0)
		$display("port 7 test done");
	endtask

	task automatic t_timer_v();
		wr(port78_pkg::OFF_P7_DIR, 8'h00);
		for (int s = 0; s < 16; s++)
		begin
			tv_sel <= s[3:0];
			tv_out <= ~s[0];
			settle();
			`CHK(p7_oe_n[6], (s == 0))
			if (s != 0)
				`CHK(p7_out[6], ~s[0])
		end
		tv_sel <= 4'h0;
		$display("timer v test done");
	endtask

	task automatic t_port8();
		wr(port78_pkg::OFF_P8_DIR, 8'hFF);
		wr(port78_pkg::OFF_P8_LAT, 8'hA5);
		ext8 <= 8'h3C;
		settle();
		`CHK(p8_oe_n, 8'h00)
		`CHK(p8_out, 8'hA5)
		xfer(port78_pkg::OFF_P8_LAT, 1'b0, 32'h0);
		`CHK(rd, 32'h000000A5)
		wr(port78_pkg::OFF_P8_DIR, 8'h0F);
		settle();
		`CHK(p8_oe_n, 8'hF0)
		xfer(port78_pkg::OFF_P8_LAT, 1'b0, 32'h0);
		`CHK(rd, 32'h00000035)
		`CHK(tw_clk, 1'b1)
		$display("port 8 test done");
	endtask

	task automatic t_timer_w();
		logic on;
		wr(port78_pkg::OFF_P8_DIR, 8'h00);
		ext8 <= 8'h0A;
		tw_out <= 4'hC;
		for (int c = 0; c < 8; c++)
		begin
			tw_ctl <= {4{c[2:0]}};
			settle();
			on = (c == 1) || (c[2:1] == 2'h1);
			`CHK(p8_oe_n[4:1], on ? 4'h0 : 4'hF)
			`CHK(tw_in, on ? 4'hC : 4'h5)
			if (on)
				`CHK(p8_out[4:1], 4'hC)
		end
		// code 1xx hands the pins back to the port direction bits
		wr(port78_pkg::OFF_P8_DIR, 8'h1E);
		wr(port78_pkg::OFF_P8_LAT, 8'h00);
		tw_ctl <= {4{3'h4}};
		settle();
		`CHK(p8_oe_n[4:1], 4'h0)
		`CHK(tw_in, 4'h0)
		// timers drive pins 4..1 over the latch; read still shows latch
		tw_ctl <= {4{3'h1}};
		settle();
		`CHK(p8_out[4:1], 4'hC)
		xfer(port78_pkg::OFF_P8_LAT, 1'b0, 32'h0);
		`CHK(rd, 32'h00000000)
		tw_ctl <= 12'h000;
		$display("timer w test done");
	endtask

	// reset in mid-run must clear latches and directions again
	task automatic t_rerun();
		wr(port78_pkg::OFF_P8_LAT, 8'hFF);
		settle();
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		settle();
		`CHK(p8_oe_n, 8'hFF)
		`CHK(p8_out, 8'h00)
		wr(port78_pkg::OFF_P8_DIR, 8'hFF);
		xfer(port78_pkg::OFF_P8_LAT, 1'b0, 32'h0);
		`CHK(rd, 32'h00000000)
		$display("mid-run reset test done");
	endtask

	initial
	begin
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_reset();
		t_port7();
		t_timer_v();
		t_port8();
		t_timer_w();
		t_rerun();
		test_done();
	end
endmodule
